// ### ssc_cfg.svh
`ifndef SSC_CFG_SVH
`define SSC_CFG_SVH

// clock period and times, each in its own unit
`define SSC_CLK_NS 5
`define SSC_REF_REV_NS 11111000
`define SSC_CHARGE_MS 100
`define SSC_TIMEOUT_MS 500
`define SSC_DRV_RST_US 10
`define SSC_COMM_STEP_US 2000

// derived cycle counts
`define SSC_REF_REV_CYC (`SSC_REF_REV_NS / `SSC_CLK_NS)
`define SSC_CHARGE_CYC (`SSC_CHARGE_MS * 1000000 / `SSC_CLK_NS)
`define SSC_TIMEOUT_CYC (`SSC_TIMEOUT_MS * 1000000 / `SSC_CLK_NS)
`define SSC_DRV_RST_CYC (`SSC_DRV_RST_US * 1000 / `SSC_CLK_NS)
`define SSC_COMM_STEP_CYC (`SSC_COMM_STEP_US * 1000 / `SSC_CLK_NS)

// feedback and gain defaults
`define SSC_PULSES_PER_REV 4
`define SSC_GAIN 1
`define SSC_QUARTERS 4

`endif

// ### ssc_drv_model.sv
`timescale 1ns/1ps

module ssc_drv_model import ssc_pkg::*; (
   // clock
   input wire logic ref_clk_i,
   // commands from the controller
   input wire ssc_drv_t drv_i,
   // motor behaviour set by the bench
   input wire logic spin_i,
   input wire logic [31:0] qp_i,
   // back-emf feedback
   output logic phase_o
);
   logic [2:0] step_q = 3'h0;
   logic run_q = 1'b0;
   int cnt_q = 0;

   always @(posedge ref_clk_i) begin
      if (drv_i.reset) begin
         run_q <= 1'b0;
         cnt_q <= 0;
         phase_o <= 1'b0;
      end else begin
         // own phase-pair stepping while in start mode
         if (drv_i.start) begin
            step_q <= (step_q == 3'h5) ? 3'h0 : step_q + 3'h1;
         end
         // motor only turns once a full phase-pair cycle has been stepped
         if (drv_i.start && spin_i && step_q == 3'h5) begin
            run_q <= 1'b1;
         end
         // keeps turning from back-emf once started
         if (run_q && spin_i) begin
            cnt_q <= (cnt_q >= int'(qp_i) - 1) ? 0 : cnt_q + 1;
            phase_o <= (cnt_q < 4);
         end else begin
            phase_o <= 1'b0;
         end
      end
   end
endmodule

// ### ssc_pkg.sv
package ssc_pkg;

   // spindle modes as seen from outside
   typedef enum logic [1:0] {
      SSC_MODE_START,
      SSC_MODE_ACCEL,
      SSC_MODE_STABLE
   } ssc_mode_t;

   // commands to the spindle_driver
   typedef struct packed {
      logic reset;
      logic start;
      logic commutate;
      logic charge;
      logic discharge;
   } ssc_drv_t;

endpackage

// ### ssc_top.sv
// Behaviour
// - the spindle runs through start, acceleration and stable rotation in order, only ever forward or back to start from reset.
// - after reset the spindle_driver is first told to charge its charge pump, whose charge sets motor current.
// - once the pump is charged the spindle_driver is put into motor start mode so start current flows.
// - with no feedback pulse within the timeout in start mode, the spindle_driver is reset and the start sequence begins again.
// - a feedback pulse during start mode moves the controller to acceleration mode.
// - in acceleration mode the commutation signal stops and the spindle_driver commutates from back-EMF.
// - in acceleration the speed is derived from feedback pulses and the pump kept charging until target speed, then stable mode.
// - in stable mode the revolution period is measured and compared against the stored reference period.
// - a short period discharges the pump, a long one charges it, for the difference times a constant gain.
// - the correction is applied once every quarter revolution in stable mode.
`timescale 1ns/1ps
`include "ssc_cfg.svh"

module ssc_top import ssc_pkg::*; #(
   parameter int CW = 32,
   parameter int REF_REV_CYC = `SSC_REF_REV_CYC,
   parameter int CHARGE_CYC = `SSC_CHARGE_CYC,
   parameter int TIMEOUT_CYC = `SSC_TIMEOUT_CYC,
   parameter int DRV_RST_CYC = `SSC_DRV_RST_CYC,
   parameter int COMM_STEP_CYC = `SSC_COMM_STEP_CYC,
   parameter int PULSES_PER_REV = `SSC_PULSES_PER_REV,
   parameter int GAIN = `SSC_GAIN
) (
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic rstn_i,
   // feedback from the spindle_driver
   input wire logic phase_i,
   // commands to the spindle_driver
   output ssc_drv_t drv_o,
   // status
   output ssc_mode_t mode_o
);

   typedef enum logic [2:0] {
      ST_CHARGE,
      ST_START,
      ST_DRV_RST,
      ST_ACCEL,
      ST_STABLE
   } ssc_state_t;

   localparam int QP = (PULSES_PER_REV / `SSC_QUARTERS) < 1 ? 1 :
                       (PULSES_PER_REV / `SSC_QUARTERS);
   localparam int SW = CW + 2;
   localparam int PW = CW + 16;

   // reset release
   logic [1:0] rst_sync_q;
   logic rst_n;
   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) rst_sync_q <= 2'h0;
      else rst_sync_q <= {rst_sync_q[0], 1'h1};
   end
   assign rst_n = rst_sync_q[1];

   // feedback synchroniser and edge detect
   logic ph_meta_q, ph_sync_q, ph_last_q;
   logic ph_edge;
   always_ff @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         ph_meta_q <= 1'h0;
         ph_sync_q <= 1'h0;
         ph_last_q <= 1'h0;
      end else begin
         ph_meta_q <= phase_i;
         ph_sync_q <= ph_meta_q;
         ph_last_q <= ph_sync_q;
      end
   end
   assign ph_edge = ph_sync_q & ~ph_last_q;

   // sequencer
   ssc_state_t state_q, state_d;
   logic [CW-1:0] tmr_q, tmr_d;
   logic [CW-1:0] comm_cnt_q;
   logic comm_q;
   logic [CW-1:0] ref_cyc;
   logic quarter_tick;
   logic [SW-1:0] new_sum;
   logic [2:0] fill_q;
   logic rev_valid;

   assign ref_cyc = CW'(REF_REV_CYC);
   assign rev_valid = (fill_q == 3'h3);

   always_comb begin
      state_d = state_q;
      tmr_d = tmr_q + CW'(1);
      unique case (state_q)
         ST_CHARGE: if (tmr_q >= CW'(CHARGE_CYC - 1)) begin
            state_d = ST_START;
            tmr_d = '0;
         end
         ST_START: if (ph_edge) begin
            state_d = ST_ACCEL;
            tmr_d = '0;
         end else if (tmr_q >= CW'(TIMEOUT_CYC - 1)) begin
            state_d = ST_DRV_RST;
            tmr_d = '0;
         end
         ST_DRV_RST: if (tmr_q >= CW'(DRV_RST_CYC - 1)) begin
            state_d = ST_CHARGE;
            tmr_d = '0;
         end
         ST_ACCEL: begin
            tmr_d = '0;
            if (quarter_tick && rev_valid && new_sum <= SW'(ref_cyc))
               state_d = ST_STABLE;
         end
         ST_STABLE: tmr_d = '0;
      endcase
   end

   always_ff @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= ST_CHARGE;
         tmr_q <= '0;
      end else begin
         state_q <= state_d;
         tmr_q <= tmr_d;
      end
   end

   // commutation stepping while in start mode only
   always_ff @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         comm_cnt_q <= '0;
         comm_q <= 1'h0;
      end else if (state_q != ST_START) begin
         comm_cnt_q <= '0;
         comm_q <= 1'h0;
      end else if (comm_cnt_q >= CW'(COMM_STEP_CYC - 1)) begin
         comm_cnt_q <= '0;
         comm_q <= ~comm_q;
      end else begin
         comm_cnt_q <= comm_cnt_q + CW'(1);
      end
   end

   // quarter revolution period measurement
   logic running;
   logic [7:0] pcnt_q;
   logic [CW-1:0] per_q;
   logic [CW-1:0] hist_q [`SSC_QUARTERS];
   logic [1:0] hidx_q;
   logic [SW-1:0] rev_sum;

   assign running = (state_q == ST_ACCEL) || (state_q == ST_STABLE);
   assign quarter_tick = running && ph_edge && (pcnt_q == 8'(QP - 1));
   assign rev_sum = SW'(hist_q[0]) + SW'(hist_q[1]) + SW'(hist_q[2]) + SW'(hist_q[3]);
   assign new_sum = rev_sum - SW'(hist_q[hidx_q]) + SW'(per_q);

   always_ff @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         pcnt_q <= '0;
         per_q <= '0;
         hidx_q <= '0;
         fill_q <= '0;
         for (int i = 0; i < `SSC_QUARTERS; i++) hist_q[i] <= '0;
      end else if (!running) begin
         pcnt_q <= '0;
         per_q <= '0;
         hidx_q <= '0;
         fill_q <= '0;
      end else begin
         if (ph_edge) pcnt_q <= quarter_tick ? 8'h00 : pcnt_q + 8'h01;
         if (quarter_tick) begin
            per_q <= CW'(1);
            hist_q[hidx_q] <= per_q;
            hidx_q <= hidx_q + 2'h1;
            if (!rev_valid) fill_q <= fill_q + 3'h1;
         end else if (per_q != '1) begin
            per_q <= per_q + CW'(1);
         end
      end
   end

   // speed correction pulse
   logic short_rev;
   logic [SW-1:0] diff;
   logic [PW-1:0] prod;
   logic [CW-1:0] dur;
   logic [CW-1:0] corr_cnt_q;
   logic corr_dis_q;

   assign short_rev = new_sum < SW'(ref_cyc);
   assign diff = short_rev ? SW'(ref_cyc) - new_sum : new_sum - SW'(ref_cyc);
   assign prod = PW'(diff) * PW'(GAIN);
   assign dur = (prod > PW'({CW{1'b1}})) ? '1 : prod[CW-1:0];

   always_ff @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         corr_cnt_q <= '0;
         corr_dis_q <= 1'h0;
      end else if (state_q != ST_STABLE) begin
         corr_cnt_q <= '0;
         corr_dis_q <= 1'h0;
      end else if (quarter_tick) begin
         corr_cnt_q <= dur;
         corr_dis_q <= short_rev;
      end else if (corr_cnt_q != '0) begin
         corr_cnt_q <= corr_cnt_q - CW'(1);
      end
   end

   // registered outputs
   ssc_drv_t drv_q;
   ssc_mode_t mode_q;
   always_ff @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         drv_q <= '0;
         mode_q <= SSC_MODE_START;
      end else begin
         drv_q.reset <= (state_q == ST_DRV_RST);
         drv_q.start <= (state_q == ST_START);
         drv_q.commutate <= comm_q && (state_q == ST_START);
         drv_q.charge <= (state_q == ST_CHARGE) || (state_q == ST_ACCEL) ||
                         ((state_q == ST_STABLE) && corr_cnt_q != '0 && !corr_dis_q);
         drv_q.discharge <= (state_q == ST_STABLE) && corr_cnt_q != '0 && corr_dis_q;
         mode_q <= (state_q == ST_ACCEL) ? SSC_MODE_ACCEL :
                   (state_q == ST_STABLE) ? SSC_MODE_STABLE : SSC_MODE_START;
      end
   end
   assign drv_o = drv_q;
   assign mode_o = mode_q;

   // checks
   sequence s_accel_entry;
      state_q == ST_START && ph_edge;
   endsequence

   a_stable_from_accel: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
      state_q == ST_STABLE && $past(state_q) != ST_STABLE |-> $past(state_q) == ST_ACCEL)
      else $error("stable entered not from accel");
   a_accel_from_pulse: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
      s_accel_entry |=> state_q == ST_ACCEL ##1 drv_o.charge && !drv_o.start)
      else $error("feedback pulse did not start acceleration");
   a_start_after_charge: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
      state_q == ST_START && $past(state_q) != ST_START |-> $past(state_q) == ST_CHARGE)
      else $error("start mode not preceded by charge");
   a_charge_then_start: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
      state_q == ST_CHARGE && $past(rst_n) |=> drv_o.charge && !drv_o.start)
      else $error("charge not driven in charge phase");
   a_timeout_reset: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
      state_q == ST_START && !ph_edge && tmr_q == CW'(TIMEOUT_CYC - 1) |-> ##2 drv_o.reset)
      else $error("timeout did not reset driver");
   a_no_comm_accel: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
      running [*2] |-> !drv_o.commutate)
      else $error("commutation issued after start mode");
   a_correct_dir: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
      state_q == ST_STABLE && quarter_tick && dur != '0 |->
         ##2 (drv_o.discharge == $past(short_rev, 2)) && (drv_o.charge == !$past(short_rev, 2)))
      else $error("correction direction wrong");
   a_pump_exclusive: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
      !(drv_o.charge && drv_o.discharge))
      else $error("charge and discharge together");
   a_corr_length: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
      state_q == ST_STABLE && quarter_tick && dur == CW'(1) && $stable(state_q) |->
         ##2 (drv_o.charge || drv_o.discharge) ##1 !(drv_o.charge || drv_o.discharge))
      else $error("one-cycle correction not one cycle long");
   // no pump pulse once the correction count has run out
   a_corr_stops: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
      state_q == ST_STABLE && corr_cnt_q == '0 && !quarter_tick |=>
         !drv_o.charge && !drv_o.discharge)
      else $error("pump pulse outlasted its correction");

endmodule

// ### test_spindle_speed_controller.sv
`timescale 1ns/1ps

module test_spindle_speed_controller import ssc_pkg::*;;
   localparam int CHG = 20;
   localparam int TMO = 200;
   localparam int RST = 4;
   localparam int REF = 400;
   logic ref_clk_i = 1'b0;
   logic rstn_i = 1'b0;
   logic phase;
   logic spin = 1'b0;
   int qp = 200;
   ssc_drv_t drv;
   ssc_mode_t mode;
   logic [4:0] dv;
   int fails = 0;
   int tests_run = 0;

   assign dv = drv;
   always #2.5 ref_clk_i = ~ref_clk_i;

   ssc_top #(.REF_REV_CYC(REF), .CHARGE_CYC(CHG), .TIMEOUT_CYC(TMO), .DRV_RST_CYC(RST),
      .COMM_STEP_CYC(5), .PULSES_PER_REV(4), .GAIN(1)) u_ssc_top (.ref_clk_i(ref_clk_i),
      .rstn_i(rstn_i), .phase_i(phase), .drv_o(drv), .mode_o(mode));
   ssc_drv_model u_ssc_drv_model (.ref_clk_i(ref_clk_i), .drv_i(drv), .spin_i(spin),
      .qp_i(qp), .phase_o(phase));

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk_i);
      #1;
   endtask

   task automatic wait_mode(input ssc_mode_t m, input int lim);
      int i;
      i = 0;
      while (mode !== m && i < lim) begin
         cyc(1);
         i++;
      end
      chk("mode", {30'h0, m}, {30'h0, mode});
   endtask

   task automatic wait_bit(input logic [4:0] msk, input int lim);
      int i;
      i = 0;
      while ((dv & msk) === 5'h00 && i < lim) begin
         cyc(1);
         i++;
      end
      chk("drv bit", {27'h0, msk}, {27'h0, dv & msk});
   endtask

   task automatic count(input int n, output int ch, output int dis);
      ch = 0;
      dis = 0;
      repeat (n) begin
         cyc(1);
         ch += (drv.charge === 1'b1);
         dis += (drv.discharge === 1'b1);
      end
   endtask

   task automatic t_power_on;
      int tg;
      logic last;
      cyc(4);
      chk("charge first", 32'h2, {27'h0, dv});
      wait_bit(5'h08, CHG + 5);
      chk("charge off in start", 32'h0, {31'h0, drv.charge});
      tg = 0;
      last = drv.commutate;
      repeat (20) begin
         cyc(1);
         if (drv.commutate !== last) tg++;
         last = drv.commutate;
      end
      chk("commutate toggles", 32'h4, tg);
      chk("mode start", 32'h0, {30'h0, mode});
   endtask

   task automatic t_timeout;
      wait_bit(5'h10, TMO + 10);
      chk("mode during retry", 32'h0, {30'h0, mode});
      wait_bit(5'h02, RST + 5);
      wait_bit(5'h08, CHG + 5);
   endtask

   task automatic t_accel;
      spin = 1'b1;
      wait_mode(SSC_MODE_ACCEL, 300);
      cyc(2);
      chk("accel drive", 32'h2, {27'h0, dv});
      cyc(4000);
      chk("still accel", 32'h1, {30'h0, mode});
   endtask

   task automatic t_stable;
      int ch;
      int dis;
      qp = 100;
      wait_mode(SSC_MODE_STABLE, 2000);
      cyc(800);
      count(800, ch, dis);
      chk("equal charge", 32'h0, ch);
      chk("equal discharge", 32'h0, dis);
   endtask

   task automatic t_fast;
      int ch;
      int dis;
      qp = 90;
      cyc(1200);
      count(360, ch, dis);
      chk("fast discharge", 32'hA0, dis);
      chk("fast charge", 32'h0, ch);
   endtask

   task automatic t_slow;
      int ch;
      int dis;
      qp = 110;
      cyc(1500);
      count(440, ch, dis);
      chk("slow charge", 32'hA0, ch);
      chk("slow discharge", 32'h0, dis);
      chk("no fall back", 32'h2, {30'h0, mode});
   endtask

   task automatic t_rereset;
      rstn_i = 1'b0;
      cyc(2);
      chk("drive in reset", 32'h0, {27'h0, dv});
      rstn_i = 1'b1;
      wait_bit(5'h02, 5);
      chk("mode after reset", 32'h0, {30'h0, mode});
   endtask

   task automatic end_of_test;
      $display("checks %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   initial begin
      cyc(3);
      rstn_i = 1'b1;
      t_power_on();
      t_timeout();
      t_accel();
      t_stable();
      t_fast();
      t_slow();
      t_rereset();
      end_of_test();
   end

   initial begin
      repeat (40000) @(posedge ref_clk_i);
      fails++;
      end_of_test();
   end
endmodule
